// ==== inc/rtccal_pkg.sv ====
// rtccal_pkg: register map, field layout and reset values of the calendar block
// assumes a 32-bit APB slave, one aligned word per register
package rtccal_pkg;
    // register byte offsets
    localparam logic [7:0] ADDR_HOUR_MINUTE = 8'h00;
    localparam logic [7:0] ADDR_MONTH_DAY   = 8'h04;
    localparam logic [7:0] ADDR_YEAR_WEEK   = 8'h08;
    localparam logic [7:0] ADDR_FLAGS       = 8'h0C;
    localparam logic [7:0] ADDR_ENABLES     = 8'h10;
    localparam logic [7:0] ADDR_CONTROL     = 8'h14;
    // hour/minute fields
    localparam int PM_BIT     = 14;
    localparam int HT_LSB     = 12;
    localparam int HU_LSB     = 8;
    localparam int MT_LSB     = 4;
    localparam int MU_LSB     = 0;
    // month/day fields
    localparam int MOT_BIT    = 12;
    localparam int MOU_LSB    = 8;
    localparam int DT_LSB     = 4;
    localparam int DU_LSB     = 0;
    // year/weekday fields
    localparam int WK_LSB     = 8;
    localparam int YT_LSB     = 4;
    localparam int YU_LSB     = 0;
    // control register fields
    localparam int CTL_MODE_BIT = 0;
    localparam int CTL_BUSY_BIT = 1;
    // flag positions
    localparam int FLAG_REG_DONE = 15;
    localparam int FLAG_SW_100   = 12;
    localparam int FLAG_ALARM    = 8;
    localparam int FLAG_DAY      = 7;
    localparam int FLAG_HOUR     = 6;
    localparam int FLAG_MINUTE   = 5;
    localparam int FLAG_SECOND   = 4;
    localparam int FLAG_SUB_LO   = 0;
    localparam logic [15:0] FLAG_MASK = 16'hF1FF;
    // reset values
    localparam logic [1:0] RST_HOUR_TENS   = 2'h1;
    localparam logic [3:0] RST_HOUR_UNITS  = 4'h2;
    localparam logic [3:0] RST_MONTH_UNITS = 4'h1;
    localparam logic [3:0] RST_DAY_UNITS   = 4'h1;
    // timing: busy lasts 1/256 s of a 32768 Hz count clock
    localparam int COUNT_CLK_HZ = 32768;
    localparam int BUSY_DIV     = 256;
    localparam int BUSY_TICKS   = COUNT_CLK_HZ / BUSY_DIV;
endpackage

// ==== core/rtccal_bcd_digit.sv ====
// rtccal_bcd_digit: one BCD digit pair counter with load and wrap
// assumes the caller gives the wrap limit and restart value each cycle
`timescale 1ns/1ps
`default_nettype none
module rtccal_bcd_digit #(
    parameter int TW = 4
) (
    // clock and reset
    input  wire logic          ref_clk,
    input  wire logic          rst_n,
    // reset value
    input  wire logic [TW-1:0] init_tens,
    input  wire logic [3:0]    init_units,
    // control
    input  wire logic          inc,
    input  wire logic          load,
    input  wire logic [TW-1:0] load_tens,
    input  wire logic [3:0]    load_units,
    input  wire logic [TW-1:0] max_tens,
    input  wire logic [3:0]    max_units,
    input  wire logic [TW-1:0] min_tens,
    input  wire logic [3:0]    min_units,
    // state
    output logic      [TW-1:0] tens,
    output logic      [3:0]    units,
    output logic               wrap
);
    logic init_done_reg;
    assign wrap = inc && tens == max_tens && units == max_units;
    // reset value arrives from ports, so it is taken one clock after release
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            init_done_reg <= 1'b0;
            tens          <= '0;
            units         <= 4'h0;
        end else if (!init_done_reg) begin
            init_done_reg <= 1'b1;
            tens          <= init_tens;
            units         <= init_units;
        end else if (load) begin
            tens  <= load_tens;
            units <= load_units;
        end else if (wrap) begin
            tens  <= min_tens;
            units <= min_units;
        end else if (inc) begin
            if (units == 4'h9) begin
                units <= 4'h0;
                tens  <= tens + TW'(1);
            end else begin
                units <= units + 4'h1;
            end
        end
    end
endmodule // rtccal_bcd_digit
`default_nettype wire

// ==== core/rtccal_top.sv ====
// rtccal_top: calendar counters, event flags and enables behind APB
// assumes minute_tick pulses once per minute and event inputs are one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module rtccal_top #(
    parameter int BUSY_CYCLES = rtccal_pkg::BUSY_TICKS
) (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // links to the rest of the clock
    input  wire logic        second_step,
    input  wire logic        minute_tick,
    input  wire logic [15:0] event_pulses,
    // status out
    output logic             count_busy,
    output logic             full_day_hour_mode,
    output logic             irq
);
    logic        wr_en;
    logic        rd_en;
    logic        low_lane;
    logic        wr_hm;
    logic        wr_md;
    logic        wr_yw;
    logic        pm_reg;
    logic        mode_reg;
    logic [15:0] flags_reg;
    logic [15:0] enables_reg;
    logic [$clog2(BUSY_CYCLES+1)-1:0] busy_cnt_reg;
    logic [1:0]  hour_tens;
    logic [3:0]  hour_units;
    logic [2:0]  minute_tens;
    logic [3:0]  minute_units;
    logic [0:0]  month_tens;
    logic [3:0]  month_units;
    logic [1:0]  day_tens;
    logic [3:0]  day_units;
    logic [3:0]  year_tens;
    logic [3:0]  year_units;
    logic [2:0]  weekday_count;
    logic        hour_inc;
    logic        hour_wrap;
    logic        day_wrap;
    logic        month_wrap;
    logic        leap;
    logic [1:0]  hmax_t;
    logic [3:0]  hmax_u;
    logic [1:0]  hmin_t;
    logic [3:0]  hmin_u;
    logic [1:0]  dmax_t;
    logic [3:0]  dmax_u;
    logic [15:0] hm_word;
    logic [15:0] md_word;
    logic [15:0] yw_word;
    logic [15:0] day_set;

    // apb decode, zero wait
    assign pready   = 1'b1;
    assign pslverr  = 1'b0;
    assign wr_en    = psel && penable && pwrite;
    assign rd_en    = psel && !pwrite;
    assign low_lane = pstrb[0] && pstrb[1];
    assign wr_hm    = wr_en && low_lane && paddr == rtccal_pkg::ADDR_HOUR_MINUTE;
    assign wr_md    = wr_en && low_lane && paddr == rtccal_pkg::ADDR_MONTH_DAY;
    assign wr_yw    = wr_en && low_lane && paddr == rtccal_pkg::ADDR_YEAR_WEEK;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_reg <= 1'b0;
        end else if (wr_en && pstrb[0] && paddr == rtccal_pkg::ADDR_CONTROL) begin
            mode_reg <= pwdata[rtccal_pkg::CTL_MODE_BIT];
        end
    end
    assign full_day_hour_mode = mode_reg;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            busy_cnt_reg <= '0;
        end else if (second_step) begin
            busy_cnt_reg <= ($clog2(BUSY_CYCLES+1))'(BUSY_CYCLES);
        end else if (busy_cnt_reg != '0) begin
            busy_cnt_reg <= busy_cnt_reg - 1'b1;
        end
    end
    assign count_busy = busy_cnt_reg != '0;

    always_comb begin
        if (mode_reg) begin
            hmax_t = 2'h2;
            hmax_u = 4'h3;
            hmin_t = 2'h0;
            hmin_u = 4'h0;
        end else begin
            hmax_t = 2'h1;
            hmax_u = 4'h2;
            hmin_t = 2'h0;
            hmin_u = 4'h1;
        end
    end
    // 12-hour mode: pm flips at 11 -> 12, day advances on every 12 -> 1 wrap point, am or pm
    assign hour_inc = minute_tick && minute_tens == 3'h5 && minute_units == 4'h9;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pm_reg <= 1'b0;
        end else if (wr_hm) begin
            pm_reg <= pwdata[rtccal_pkg::PM_BIT] && !mode_reg;
        end else if (hour_inc && mode_reg) begin
            pm_reg <= 1'b0;
        end else if (hour_inc && hour_tens == 2'h1 && hour_units == 4'h1) begin
            pm_reg <= !pm_reg;
        end
    end

    rtccal_bcd_digit #(.TW(3)) u_minute (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .init_tens(3'h0), .init_units(4'h0),
        .inc(minute_tick), .load(wr_hm),
        .load_tens(pwdata[rtccal_pkg::MT_LSB +: 3]),
        .load_units(pwdata[rtccal_pkg::MU_LSB +: 4]),
        .max_tens(3'h5), .max_units(4'h9), .min_tens(3'h0), .min_units(4'h0),
        .tens(minute_tens), .units(minute_units), .wrap()
    );

    rtccal_bcd_digit #(.TW(2)) u_hour (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .init_tens(rtccal_pkg::RST_HOUR_TENS), .init_units(rtccal_pkg::RST_HOUR_UNITS),
        .inc(hour_inc), .load(wr_hm),
        .load_tens(pwdata[rtccal_pkg::HT_LSB +: 2]),
        .load_units(pwdata[rtccal_pkg::HU_LSB +: 4]),
        .max_tens(hmax_t), .max_units(hmax_u), .min_tens(hmin_t), .min_units(hmin_u),
        .tens(hour_tens), .units(hour_units), .wrap(hour_wrap)
    );

    // leap year test on BCD value
    assign leap = year_tens[0] ? (year_units == 4'h2 || year_units == 4'h6)
                               : (year_units == 4'h0 || year_units == 4'h4 ||
                                  year_units == 4'h8);

    always_comb begin
        dmax_t = 2'h3;
        dmax_u = 4'h1;
        if (month_tens == 1'b0 && month_units == 4'h2) begin
            dmax_t = 2'h2;
            dmax_u = leap ? 4'h9 : 4'h8;
        end else if ((month_tens == 1'b0 && (month_units == 4'h4 || month_units == 4'h6 ||
                      month_units == 4'h9)) || (month_tens == 1'b1 && month_units == 4'h1)) begin
            dmax_u = 4'h0;
        end
    end

    rtccal_bcd_digit #(.TW(2)) u_day (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .init_tens(2'h0), .init_units(rtccal_pkg::RST_DAY_UNITS),
        .inc(hour_wrap), .load(wr_md),
        .load_tens(pwdata[rtccal_pkg::DT_LSB +: 2]),
        .load_units(pwdata[rtccal_pkg::DU_LSB +: 4]),
        .max_tens(dmax_t), .max_units(dmax_u), .min_tens(2'h0), .min_units(4'h1),
        .tens(day_tens), .units(day_units), .wrap(day_wrap)
    );

    rtccal_bcd_digit #(.TW(1)) u_month (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .init_tens(1'b0), .init_units(rtccal_pkg::RST_MONTH_UNITS),
        .inc(day_wrap), .load(wr_md),
        .load_tens(pwdata[rtccal_pkg::MOT_BIT +: 1]),
        .load_units(pwdata[rtccal_pkg::MOU_LSB +: 4]),
        .max_tens(1'b1), .max_units(4'h2), .min_tens(1'b0), .min_units(4'h1),
        .tens(month_tens), .units(month_units), .wrap(month_wrap)
    );

    rtccal_bcd_digit #(.TW(4)) u_year (
        .ref_clk(ref_clk), .rst_n(rst_n),
        .init_tens(4'h0), .init_units(4'h0),
        .inc(month_wrap), .load(wr_yw),
        .load_tens(pwdata[rtccal_pkg::YT_LSB +: 4]),
        .load_units(pwdata[rtccal_pkg::YU_LSB +: 4]),
        .max_tens(4'h9), .max_units(4'h9), .min_tens(4'h0), .min_units(4'h0),
        .tens(year_tens), .units(year_units), .wrap()
    );

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            weekday_count <= 3'h0;
        end else if (wr_yw) begin
            weekday_count <= pwdata[rtccal_pkg::WK_LSB +: 3];
        end else if (hour_wrap) begin
            weekday_count <= (weekday_count == 3'h6) ? 3'h0 : weekday_count + 3'h1;
        end
    end

    // flag causes; calendar day and hour come from here
    always_comb begin
        day_set = event_pulses & rtccal_pkg::FLAG_MASK;
        day_set[rtccal_pkg::FLAG_DAY]  = event_pulses[rtccal_pkg::FLAG_DAY] || hour_wrap;
        day_set[rtccal_pkg::FLAG_HOUR] = event_pulses[rtccal_pkg::FLAG_HOUR] || hour_inc;
        day_set[rtccal_pkg::FLAG_MINUTE] = event_pulses[rtccal_pkg::FLAG_MINUTE] || minute_tick;
    end

    // write 1 clears, a set in the same cycle wins
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_reg <= 16'h0000;
        end else begin
            flags_reg <= ((wr_en && low_lane && paddr == rtccal_pkg::ADDR_FLAGS)
                          ? (flags_reg & ~pwdata[15:0]) : flags_reg) | day_set;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            enables_reg <= 16'h0000;
        end else if (wr_en && low_lane && paddr == rtccal_pkg::ADDR_ENABLES) begin
            enables_reg <= pwdata[15:0] & rtccal_pkg::FLAG_MASK;
        end
    end

    assign irq = |(flags_reg & enables_reg);

    // read mux
    // a pm left from 12h mode stays visible until the next hour step or hour/minute write
    assign hm_word = {1'b0, pm_reg, hour_tens, hour_units, 1'b0,
                      minute_tens, minute_units};
    assign md_word = {3'h0, month_tens, month_units, 2'h0, day_tens, day_units};
    assign yw_word = {5'h00, weekday_count, year_tens, year_units};
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (rd_en && !penable) begin
            case (paddr)
                rtccal_pkg::ADDR_HOUR_MINUTE: prdata <= {16'h0000, hm_word};
                rtccal_pkg::ADDR_MONTH_DAY:   prdata <= {16'h0000, md_word};
                rtccal_pkg::ADDR_YEAR_WEEK:   prdata <= {16'h0000, yw_word};
                rtccal_pkg::ADDR_FLAGS:       prdata <= {16'h0000, flags_reg};
                rtccal_pkg::ADDR_ENABLES:     prdata <= {16'h0000, enables_reg};
                rtccal_pkg::ADDR_CONTROL:     prdata <= {30'h0, count_busy, mode_reg};
                default:                      prdata <= 32'h0000_0000;
            endcase
        end
    end

    property p_pm_zero_24h;
        @(posedge ref_clk) disable iff (!rst_n)
        wr_hm && mode_reg |=> !pm_reg;
    endproperty
    a_pm_zero_24h: assert property (p_pm_zero_24h) else $error("pm write taken in 24h");
    property p_min_range;
        @(posedge ref_clk) disable iff (!rst_n)
        minute_tick && !wr_hm && minute_tens == 3'h5 && minute_units == 4'h9
            |=> minute_tens == 3'h0 && minute_units == 4'h0;
    endproperty
    a_min_range: assert property (p_min_range) else $error("minute wrap wrong");
    property p_wk_wrap;
        @(posedge ref_clk) disable iff (!rst_n)
        hour_wrap && !wr_yw && weekday_count == 3'h6 |=> weekday_count == 3'h0;
    endproperty
    a_wk_wrap: assert property (p_wk_wrap) else $error("weekday wrap wrong");
    property p_set_wins;
        @(posedge ref_clk) disable iff (!rst_n)
        day_set[rtccal_pkg::FLAG_MINUTE] |=> flags_reg[rtccal_pkg::FLAG_MINUTE];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("flag set lost");
    property p_irq;
        @(posedge ref_clk) disable iff (!rst_n)
        |(day_set & enables_reg) && !(wr_en && paddr == rtccal_pkg::ADDR_ENABLES) |=> irq;
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");
    property p_busy;
        @(posedge ref_clk) disable iff (!rst_n)
        second_step |=> count_busy [*2];
    endproperty
    a_busy: assert property (p_busy) else $error("busy not held");
    property p_day_carry;
        @(posedge ref_clk) disable iff (!rst_n)
        day_wrap && !wr_md |=> day_units == 4'h1 && day_tens == 2'h0;
    endproperty
    a_day_carry: assert property (p_day_carry) else $error("day wrap wrong");
    property p_pm_clear;
        @(posedge ref_clk) disable iff (!rst_n)
        hour_inc && mode_reg && !wr_hm |=> !pm_reg;
    endproperty
    a_pm_clear: assert property (p_pm_clear) else $error("pm kept in 24h");
endmodule // rtccal_top
`default_nettype wire

// ==== tb/rtccal_top_tb_top.sv ====
// rtccal_top_tb_top: self-checking bench for the calendar, flag and enable block
// assumes rtccal_top behind a zero-wait APB slave, ticks driven directly by the bench
`timescale 1ns/1ps
`default_nettype none
module rtccal_top_tb_top;
    // short busy window keeps the run brief
    localparam int BUSY_N = 4;
    logic        ref_clk;
    logic        rst_n;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        second_step;
    logic        minute_tick;
    logic [15:0] event_pulses;
    logic        count_busy;
    logic        full_day_hour_mode;
    logic        irq;
    logic [31:0] rd;
    int          errors;
    int          checks_done;
    int          cnt;
    // date steps from 23:59: year/week and month/day before and after
    logic [15:0] ym_in  [8] = '{16'h0600, 16'h0201, 16'h0024, 16'h0399,
                                16'h0150, 16'h0150, 16'h0150, 16'h0150};
    logic [15:0] md_in  [8] = '{16'h0228, 16'h0228, 16'h0229, 16'h1231,
                                16'h0430, 16'h0130, 16'h0930, 16'h1130};
    logic [15:0] ym_out [8] = '{16'h0000, 16'h0301, 16'h0124, 16'h0400,
                                16'h0250, 16'h0250, 16'h0250, 16'h0250};
    logic [15:0] md_out [8] = '{16'h0229, 16'h0301, 16'h0301, 16'h0101,
                                16'h0501, 16'h0131, 16'h1001, 16'h1201};

    rtccal_top #(
        .BUSY_CYCLES (BUSY_N)
    ) u_dut (
        .ref_clk            (ref_clk),
        .rst_n              (rst_n),
        .psel               (psel),
        .penable            (penable),
        .pwrite             (pwrite),
        .paddr              (paddr),
        .pwdata             (pwdata),
        .pstrb              (4'hF),
        .prdata             (prdata),
        .pready             (pready),
        .pslverr            (pslverr),
        .second_step        (second_step),
        .minute_tick        (minute_tick),
        .event_pulses       (event_pulses),
        .count_busy         (count_busy),
        .full_day_hour_mode (full_day_hour_mode),
        .irq                (irq)
    );

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // outputs are looked at on the falling edge, after the rising edge has landed
    // which: 0 irq, 1 mode output, 2 busy; taken after the edge, not at the call
    task automatic check_pin(input int which, input logic exp, input string what);
        logic got;
        @(negedge ref_clk);
        got = (which == 0) ? irq : (which == 1) ? full_day_hour_mode : count_busy;
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t %s got %b exp %b", $time, what, got, exp);
        end
    endtask

    // one APB transfer; request held until pready is seen high
    task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data);
        int k;
        @(posedge ref_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge ref_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (pready !== 1'b1 || pslverr !== 1'b0) begin
            errors++;
            $display("MISMATCH t=%0t no ready or error", $time);
            complete_run();
        end
        rd = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        apb_xfer(1'b1, a, {16'h0000, d});
    endtask

    task automatic chk(input logic [7:0] a, input logic [15:0] e, input string what);
        apb_xfer(1'b0, a, 32'h0000_0000);
        check_word(rd, {16'h0000, e}, what);
    endtask

    // one-cycle pulse: 0 second step, 1 minute tick, 2 event causes
    task automatic pulse(input int which, input logic [15:0] ev);
        @(posedge ref_clk);
        if (which == 0) begin
            second_step <= 1'b1;
        end else if (which == 1) begin
            minute_tick <= 1'b1;
        end else begin
            event_pulses <= ev;
        end
        @(posedge ref_clk);
        second_step  <= 1'b0;
        minute_tick  <= 1'b0;
        event_pulses <= 16'h0000;
    endtask

    initial begin
        rst_n        = 1'b0;
        psel         = 1'b0;
        penable      = 1'b0;
        pwrite       = 1'b0;
        paddr        = 8'h00;
        pwdata       = 32'h0000_0000;
        second_step  = 1'b0;
        minute_tick  = 1'b0;
        event_pulses = 16'h0000;
        errors       = 0;
        checks_done  = 0;
        repeat (3) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk(rtccal_pkg::ADDR_HOUR_MINUTE, 16'h1200, "hour reset");
        chk(rtccal_pkg::ADDR_MONTH_DAY, 16'h0101, "date reset");
        chk(rtccal_pkg::ADDR_YEAR_WEEK, 16'h0000, "year reset");
        chk(rtccal_pkg::ADDR_FLAGS, 16'h0000, "flag reset");
        chk(rtccal_pkg::ADDR_ENABLES, 16'h0000, "enable reset");
        check_pin(0, 1'b0, "irq reset");
        $display("test reset values done");
        // 12-hour mode: pm bit, 11 pm to 12 am, 12 to 1 moves the day
        wr(rtccal_pkg::ADDR_HOUR_MINUTE, 16'h5159);
        chk(rtccal_pkg::ADDR_HOUR_MINUTE, 16'h5159, "pm write");
        wr(8'h18, 16'hFFFF);
        chk(8'h18, 16'h0000, "unmapped");
        pulse(1, 16'h0000);
        chk(rtccal_pkg::ADDR_HOUR_MINUTE, 16'h1200, "11 to 12");
        chk(rtccal_pkg::ADDR_MONTH_DAY, 16'h0101, "no day step");
        wr(rtccal_pkg::ADDR_HOUR_MINUTE, 16'h1259);
        pulse(1, 16'h0000);
        chk(rtccal_pkg::ADDR_HOUR_MINUTE, 16'h0100, "12 to 1");
        chk(rtccal_pkg::ADDR_MONTH_DAY, 16'h0102, "day step");
        chk(rtccal_pkg::ADDR_YEAR_WEEK, 16'h0100, "weekday step");
        $display("test 12 hour done");
        // switch to 24-hour with pm set: kept until the next hour step or hour/minute write
        wr(rtccal_pkg::ADDR_HOUR_MINUTE, 16'h4559);
        wr(rtccal_pkg::ADDR_CONTROL, 16'h0001);
        check_pin(1, 1'b1, "mode out");
        chk(rtccal_pkg::ADDR_CONTROL, 16'h0001, "mode read");
        chk(rtccal_pkg::ADDR_HOUR_MINUTE, 16'h4559, "pm kept");
        pulse(1, 16'h0000);
        chk(rtccal_pkg::ADDR_HOUR_MINUTE, 16'h0600, "pm cleared");
        wr(rtccal_pkg::ADDR_HOUR_MINUTE, 16'h4123);
        chk(rtccal_pkg::ADDR_HOUR_MINUTE, 16'h0123, "pm refused");
        check_pin(2, 1'b0, "idle before loads");
        for (int i = 0; i < 8; i++) begin
            wr(rtccal_pkg::ADDR_YEAR_WEEK, ym_in[i]);
            wr(rtccal_pkg::ADDR_MONTH_DAY, md_in[i]);
            wr(rtccal_pkg::ADDR_HOUR_MINUTE, 16'h2359);
            pulse(1, 16'h0000);
            chk(rtccal_pkg::ADDR_HOUR_MINUTE, 16'h0000, "23 to 0");
            chk(rtccal_pkg::ADDR_MONTH_DAY, md_out[i], "date step");
            chk(rtccal_pkg::ADDR_YEAR_WEEK, ym_out[i], "year step");
        end
        $display("test 24 hour calendar done");
        // busy window after a second step
        cnt = 0;
        @(posedge ref_clk);
        second_step <= 1'b1;
        for (int i = 0; i < 40; i++) begin
            @(posedge ref_clk);
            second_step <= 1'b0;
            @(negedge ref_clk);
            if (count_busy === 1'b1) begin
                cnt++;
            end
        end
        check_word(32'(cnt), 32'(BUSY_N), "busy length");
        $display("test busy done");
        // each flag position, write-one-clear, enables and irq
        wr(rtccal_pkg::ADDR_FLAGS, 16'hFFFF);
        chk(rtccal_pkg::ADDR_FLAGS, 16'h0000, "flags cleared");
        for (int i = 0; i < 16; i++) begin
            pulse(2, 16'h0001 << i);
            chk(rtccal_pkg::ADDR_FLAGS, (16'h0001 << i) & rtccal_pkg::FLAG_MASK, "flag");
            wr(rtccal_pkg::ADDR_FLAGS, 16'hFFFF);
        end
        pulse(2, 16'hFFFF);
        wr(rtccal_pkg::ADDR_FLAGS, 16'h0000);
        chk(rtccal_pkg::ADDR_FLAGS, 16'hF1FF, "write 0 keeps");
        check_pin(0, 1'b0, "irq masked");
        wr(rtccal_pkg::ADDR_ENABLES, 16'hFFFF);
        chk(rtccal_pkg::ADDR_ENABLES, 16'hF1FF, "enables");
        wr(rtccal_pkg::ADDR_ENABLES, 16'h0001);
        check_pin(0, 1'b1, "irq on");
        wr(rtccal_pkg::ADDR_FLAGS, 16'h0001);
        chk(rtccal_pkg::ADDR_FLAGS, 16'hF1FE, "one cleared");
        check_pin(0, 1'b0, "irq off");
        wr(rtccal_pkg::ADDR_ENABLES, 16'h8000);
        check_pin(0, 1'b1, "irq top bit");
        wr(rtccal_pkg::ADDR_FLAGS, 16'hFFFF);
        check_pin(0, 1'b0, "irq cleared");
        pulse(2, 16'h8000);
        check_pin(0, 1'b1, "irq on new cause");
        $display("test flags done");
        complete_run();
    end
endmodule // rtccal_top_tb_top
`default_nettype wire
